/* File: src/cspl_params.svh */
// Offsets, field positions, reset values and counts of the second-stage path and input monitor.
`ifndef CSPL_PARAMS_SVH
`define CSPL_PARAMS_SVH

// ==========================================================================
// Register offsets
`define CSPL_ADDR_CTRL 8'h00
`define CSPL_ADDR_INTDIV 8'h04
`define CSPL_ADDR_FRACINT 8'h08
`define CSPL_ADDR_FRACFRAC 8'h0C
`define CSPL_ADDR_LOSCFG 8'h10
`define CSPL_ADDR_STATUS 8'h14
`define CSPL_ADDR_MASK 8'h18

// ==========================================================================
// Field positions
`define CSPL_CTRL_BYPASS 0
`define CSPL_CTRL_DOUBLER 1
`define CSPL_CTRL_FEED 2
`define CSPL_CTRL_PREDIV_LSB 8
`define CSPL_CTRL_FBDIV_LSB 16
`define CSPL_LOSCFG_MON1_LSB 8
`define CSPL_LOSCFG_REVAL_LSB 16
`define CSPL_STATUS_LATCHED_LSB 4
`define CSPL_STATUS_VCO_OK 8

// ==========================================================================
// Reset values and limits
`define CSPL_RST_PREDIV 6'h01
`define CSPL_RST_FBDIV 9'h00A
`define CSPL_RST_INTDIV 8'h14
`define CSPL_RST_FRACINT 4'h7
`define CSPL_RST_MONDIV 5'h05
`define CSPL_RST_REVAL 8'h08
`define CSPL_FBDIV_MIN 9'h008
`define CSPL_FRACINT_MAX 4'hE
`define CSPL_MISS_LIMIT 2'h3
`define CSPL_VCO_TARGET_KHZ 48'h0000_0026_25A0

`endif

/* File: src/cspl_pkg.sv */
// Types shared by the second-stage path controller and its input monitors.
`default_nettype none
package cspl_pkg;
  typedef logic [7:0] cspl_intdiv_t;
  typedef logic [4:0] cspl_mondiv_t;
  typedef logic [7:0] cspl_reval_t;
  typedef logic [1:0] cspl_miss_t;
endpackage : cspl_pkg
`default_nettype wire

/* File: src/cspl_los_mon.sv */
// Loss-of-signal detector for one reference input.
`timescale 1ns/100ps
`default_nettype none
`include "cspl_params.svh"

module cspl_los_mon
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic vcxo_edge_in,
  input wire logic ref_level_in,
  input wire logic diff_zero_in,
  input wire cspl_pkg::cspl_mondiv_t mon_div_in,
  input wire cspl_pkg::cspl_reval_t reval_in,
  output logic lost_out,
  output logic lost_set_out
);

  // ==========================================================================
  // Window timing
  logic ref_prev_q;
  logic ref_edge;
  cspl_pkg::cspl_mondiv_t win_cnt_q;
  logic window_end;
  logic seen_q;
  logic period_ok;
  cspl_pkg::cspl_miss_t miss_q;
  cspl_pkg::cspl_reval_t good_q;
  logic lost_q;
  logic miss_fault;
  logic declare;

  // Only rising edges count, so a fast input never looks like a fault.
  assign ref_edge = ref_level_in & ~ref_prev_q; // RULE_15
  assign window_end = vcxo_edge_in && (5'(win_cnt_q + 5'h01) >= mon_div_in); // RULE_09
  assign period_ok = seen_q | ref_edge;
  assign miss_fault = window_end && !period_ok && (2'(miss_q + 2'h1) == `CSPL_MISS_LIMIT); // RULE_10
  assign declare = enable_in && (miss_fault || diff_zero_in); // RULE_11

  // Tracking the pin through reset keeps an input that is high at release from looking like a fresh edge.
  always_ff @(posedge clk_sys_in)
  begin
    ref_prev_q <= ref_level_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable_in)
      win_cnt_q <= 5'h00;
    else if (window_end)
      win_cnt_q <= 5'h00;
    else if (vcxo_edge_in)
      win_cnt_q <= 5'(win_cnt_q + 5'h01);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable_in)
      seen_q <= 1'b0;
    else
      // An edge in the closing cycle counts for that window only, so it cannot cover the next one.
      seen_q <= ~window_end & (seen_q | ref_edge); // RULE_10
  end

  // ==========================================================================
  // Missing-edge count
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable_in)
      miss_q <= 2'h0;
    else if (ref_edge)
      miss_q <= 2'h0; // RULE_18
    else if (window_end && !seen_q && miss_q != `CSPL_MISS_LIMIT)
      miss_q <= 2'(miss_q + 2'h1);
  end

  // ==========================================================================
  // Loss state and re-validation
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable_in)
    begin
      lost_q <= 1'b0; // RULE_14
      good_q <= 8'h00;
    end
    else if (declare)
    begin
      lost_q <= 1'b1;
      good_q <= 8'h00;
    end
    else if (lost_q && window_end)
    begin
      if (!period_ok)
        good_q <= 8'h00;
      else if (8'(good_q + 8'h01) >= reval_in)
      begin
        lost_q <= 1'b0; // RULE_16
        good_q <= 8'h00;
      end
      else
        good_q <= 8'(good_q + 8'h01);
    end
  end

  assign lost_out = lost_q;
  assign lost_set_out = declare & ~lost_q;

  // ==========================================================================
  // Checks
  a_miss_declares: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_10
    (enable_in && miss_q == 2'h2 && window_end && !seen_q && !ref_edge) |=> lost_q)
    else $error("third missing edge did not declare loss");
  a_bypass_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_14
    !enable_in |=> !lost_q)
    else $error("loss flagged while monitor disabled");
  a_diff_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_11
    (enable_in && diff_zero_in) |=> lost_q)
    else $error("zero differential input not flagged");
  a_edge_restart: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_18
    (enable_in && ref_edge) |=> miss_q == 2'h0)
    else $error("input edge did not restart miss count");
  a_reval_needs_edge: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_16
    (lost_q && enable_in && !period_ok) |=> lost_q)
    else $error("loss cleared without a returned period");
  c_loss_seen: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(lost_q));
  c_reval_seen: cover property (@(posedge clk_sys_in) disable iff (rst_in) $fell(lost_q) && enable_in);

endmodule : cspl_los_mon

`default_nettype wire

/* File: src/cspl_top.sv */
// Second-stage PLL path configuration, output channel dividers and reference loss monitoring.
// Notes on behaviour
// (RULE_01) Unbypassed: second stage aims at 2500MHz VCO.
// (RULE_02) Doubler off: reference divided by pre-divider.
// (RULE_03) Doubler on: reference doubled, pre-divider ignored.
// (RULE_04) Feed select picks second stage or first.
// (RULE_05) Five channels: four integer, one fractional.
// (RULE_06) Integer dividers 1 to 160, supported set.
// (RULE_07) Fractional divider integer part at most 14.
// (RULE_08) One loss detector per reference input.
// (RULE_09) Detectors compare against divided VCXO clock.
// (RULE_10) Three missing edges declare input lost.
// (RULE_11) Zero differential voltage also declares loss.
// (RULE_12) Software sets monitor divider to match input.
// (RULE_13) Live and sticky flags, active-low interrupt.
// (RULE_14) Detection runs only when first stage active.
// (RULE_15) Only missing edges count, not frequency.
// (RULE_16) Re-validate after configured count of periods.
// (RULE_17) Bypassed: input clock is second-stage reference.
// (RULE_18) Input edge restarts the miss counter.
// (RULE_19) Sticky flag holds until software clears it.
`timescale 1ns/100ps
`default_nettype none
`include "cspl_params.svh"

module cspl_top
#(
  parameter logic [31:0] VCXO_KHZ = 32'd125000,
  parameter int NUM_INPUTS = 2,
  parameter int NUM_INT_CH = 4
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic vcxo_div_in,
  input wire logic [1:0] ref_clk_in,
  input wire logic [1:0] diff_zero_in,
  output logic first_stage_bypass_out,
  output logic pll2_ref_from_input_out,
  output logic ref_doubler_on_out,
  output logic [5:0] pll2_ref_div_out,
  output logic [8:0] second_stage_fb_div_out,
  output logic divider_feed_select_out,
  output logic manual_select_required_out,
  output logic vco_config_ok_out,
  output logic [31:0] integer_channel_div_out,
  output logic [3:0] fractional_channel_int_out,
  output logic [23:0] fractional_channel_frac_out,
  output logic [1:0] loss_live_flag_out,
  output logic [1:0] loss_latched_flag_out,
  output logic irq_out_low
);

  // ==========================================================================
  // Elaboration checks
  if (NUM_INPUTS != 2)
  begin : g_bad_inputs
    $error("the monitor and status layout serve exactly two inputs");
  end
  if (NUM_INT_CH != 4)
  begin : g_bad_channels
    $error("the integer divider register holds exactly four channels");
  end
  if (VCXO_KHZ == 32'd0)
  begin : g_bad_vcxo
    $error("VCXO frequency must be non-zero");
  end

  // ==========================================================================
  // Helpers
  function automatic logic intdiv_supported(input cspl_pkg::cspl_intdiv_t div);
    unique case (div)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h10, 8'h14, 8'h1E,
      8'h20, 8'h28, 8'h32, 8'h3C, 8'h40, 8'h50, 8'h64, 8'h78, 8'h80, 8'hA0:
        intdiv_supported = 1'b1;
      default:
        intdiv_supported = 1'b0;
    endcase
  endfunction : intdiv_supported

  function automatic logic is_write(input logic [7:0] addr, input logic [7:0] target, input logic wr);
    is_write = wr && (addr == target);
  endfunction : is_write

  // ==========================================================================
  // Configuration registers
  logic bypass_q;
  logic doubler_q;
  logic feed_q;
  logic [5:0] prediv_q;
  logic [8:0] fbdiv_q;
  cspl_pkg::cspl_intdiv_t intdiv_q [NUM_INT_CH];
  logic [3:0] fracint_q;
  logic [23:0] fracfrac_q;
  cspl_pkg::cspl_mondiv_t mondiv_q [NUM_INPUTS];
  cspl_pkg::cspl_reval_t reval_q;
  logic [1:0] mask_q;
  logic [1:0] latched_q;
  logic [31:0] rdata_q;
  logic wr_ctrl;
  logic wr_status;
  logic [5:0] wr_prediv;
  logic [8:0] wr_fbdiv;

  assign wr_ctrl = is_write(reg_addr_in, `CSPL_ADDR_CTRL, reg_wr_in);
  assign wr_status = is_write(reg_addr_in, `CSPL_ADDR_STATUS, reg_wr_in);
  assign wr_prediv = reg_wdata_in[`CSPL_CTRL_PREDIV_LSB +: 6];
  assign wr_fbdiv = reg_wdata_in[`CSPL_CTRL_FBDIV_LSB +: 9];

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      bypass_q <= 1'b0;
      doubler_q <= 1'b1;
      feed_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      bypass_q <= reg_wdata_in[`CSPL_CTRL_BYPASS];
      doubler_q <= reg_wdata_in[`CSPL_CTRL_DOUBLER];
      feed_q <= reg_wdata_in[`CSPL_CTRL_FEED];
    end
  end

  // A zero pre-divider or a feedback divider under its minimum would stall the loop, so such a field keeps its value.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      prediv_q <= `CSPL_RST_PREDIV;
      fbdiv_q <= `CSPL_RST_FBDIV;
    end
    else if (wr_ctrl)
    begin
      if (wr_prediv != 6'h00)
        prediv_q <= wr_prediv;
      if (wr_fbdiv >= `CSPL_FBDIV_MIN)
        fbdiv_q <= wr_fbdiv;
    end
  end

  // An unsupported ratio in one byte lane leaves that channel alone; the other lanes still update.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NUM_INT_CH; i++)
        intdiv_q[i] <= `CSPL_RST_INTDIV;
    end
    else if (is_write(reg_addr_in, `CSPL_ADDR_INTDIV, reg_wr_in))
    begin
      for (int i = 0; i < NUM_INT_CH; i++)
        if (intdiv_supported(reg_wdata_in[8*i +: 8]))
          intdiv_q[i] <= reg_wdata_in[8*i +: 8]; // RULE_06
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      fracint_q <= `CSPL_RST_FRACINT;
    else if (is_write(reg_addr_in, `CSPL_ADDR_FRACINT, reg_wr_in) && reg_wdata_in[3:0] <= `CSPL_FRACINT_MAX
             && reg_wdata_in[31:4] == 28'h0)
      fracint_q <= reg_wdata_in[3:0]; // RULE_07
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      fracfrac_q <= 24'h000000;
    else if (is_write(reg_addr_in, `CSPL_ADDR_FRACFRAC, reg_wr_in))
      fracfrac_q <= reg_wdata_in[23:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      mondiv_q[0] <= `CSPL_RST_MONDIV;
      mondiv_q[1] <= `CSPL_RST_MONDIV;
      reval_q <= `CSPL_RST_REVAL;
    end
    else if (is_write(reg_addr_in, `CSPL_ADDR_LOSCFG, reg_wr_in))
    begin
      mondiv_q[0] <= reg_wdata_in[4:0]; // RULE_12
      mondiv_q[1] <= reg_wdata_in[`CSPL_LOSCFG_MON1_LSB +: 5];
      reval_q <= reg_wdata_in[`CSPL_LOSCFG_REVAL_LSB +: 8];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      mask_q <= 2'h0;
    else if (is_write(reg_addr_in, `CSPL_ADDR_MASK, reg_wr_in))
      mask_q <= reg_wdata_in[1:0];
  end

  // ==========================================================================
  // Second-stage reference path
  logic [47:0] vco_lhs;
  logic [47:0] vco_rhs;

  assign pll2_ref_from_input_out = bypass_q; // RULE_17
  assign manual_select_required_out = bypass_q; // RULE_17
  assign pll2_ref_div_out = doubler_q ? 6'h01 : prediv_q; // RULE_02 RULE_03
  assign divider_feed_select_out = feed_q; // RULE_04

  // The VCO lands on target when ref * mult * fb / div equals 2500MHz; cross-multiplied to avoid a divider.
  always_comb
  begin
    vco_lhs = 48'(VCXO_KHZ) * 48'(fbdiv_q);
    vco_rhs = `CSPL_VCO_TARGET_KHZ * 48'(pll2_ref_div_out);
    if (doubler_q)
      vco_lhs = 48'(vco_lhs << 1);
  end

  // ==========================================================================
  // Loss-of-signal monitoring
  logic vcxo_prev_q;
  logic vcxo_edge;
  wire logic [1:0] lost;
  wire logic [1:0] lost_set;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      vcxo_prev_q <= 1'b0;
    else
      vcxo_prev_q <= vcxo_div_in;
  end

  assign vcxo_edge = vcxo_div_in & ~vcxo_prev_q; // RULE_09

  for (genvar g = 0; g < NUM_INPUTS; g++)
  begin : g_mon
    cspl_los_mon u_mon // RULE_08
    (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .enable_in(~bypass_q),
      .vcxo_edge_in(vcxo_edge),
      .ref_level_in(ref_clk_in[g]),
      .diff_zero_in(diff_zero_in[g]),
      .mon_div_in(mondiv_q[g]),
      .reval_in(reval_q),
      .lost_out(lost[g]),
      .lost_set_out(lost_set[g])
    );
  end

  // Write one to clear; a loss arriving in the same cycle as the clear keeps the flag set.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      latched_q <= 2'h0;
    else if (wr_status)
      latched_q <= (latched_q & ~reg_wdata_in[`CSPL_STATUS_LATCHED_LSB +: 2]) | lost_set; // RULE_19
    else
      latched_q <= latched_q | lost_set; // RULE_13
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !reg_rd_in)
      rdata_q <= 32'h0000_0000;
    else
    begin
      unique case (reg_addr_in)
        `CSPL_ADDR_CTRL:
          rdata_q <= {7'h00, fbdiv_q, 2'h0, prediv_q, 5'h00, feed_q, doubler_q, bypass_q};
        `CSPL_ADDR_INTDIV:
          rdata_q <= {intdiv_q[3], intdiv_q[2], intdiv_q[1], intdiv_q[0]};
        `CSPL_ADDR_FRACINT:
          rdata_q <= {28'h0, fracint_q};
        `CSPL_ADDR_FRACFRAC:
          rdata_q <= {8'h00, fracfrac_q};
        `CSPL_ADDR_LOSCFG:
          rdata_q <= {8'h00, reval_q, 3'h0, mondiv_q[1], 3'h0, mondiv_q[0]};
        `CSPL_ADDR_STATUS:
          rdata_q <= {23'h0, vco_config_ok_out, 2'h0, latched_q, 2'h0, lost};
        `CSPL_ADDR_MASK:
          rdata_q <= {30'h0, mask_q};
        default:
          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_out = rdata_q;
  assign first_stage_bypass_out = bypass_q;
  assign ref_doubler_on_out = doubler_q;
  assign second_stage_fb_div_out = fbdiv_q;
  assign vco_config_ok_out = !bypass_q && (vco_lhs == vco_rhs); // RULE_01
  assign integer_channel_div_out = {intdiv_q[3], intdiv_q[2], intdiv_q[1], intdiv_q[0]}; // RULE_05
  assign fractional_channel_int_out = fracint_q;
  assign fractional_channel_frac_out = fracfrac_q;
  assign loss_live_flag_out = lost; // RULE_13
  assign loss_latched_flag_out = latched_q;
  assign irq_out_low = ~|(latched_q & mask_q); // RULE_13

  // ==========================================================================
  // Checks
  a_sticky_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_19
    (latched_q[0] && !(wr_status && reg_wdata_in[`CSPL_STATUS_LATCHED_LSB])) |=> latched_q[0])
    else $error("sticky loss flag dropped without a clear");
  a_sticky_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_13
    $rose(lost[1]) |-> latched_q[1] && !(irq_out_low && mask_q[1]))
    else $error("loss did not latch or raise the interrupt");
  a_doubler_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_03
    (wr_ctrl && reg_wdata_in[`CSPL_CTRL_DOUBLER]) |=> pll2_ref_div_out == 6'h01)
    else $error("pre-divider applied with doubler on");
  a_prediv_used: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_02
    (wr_ctrl && !reg_wdata_in[`CSPL_CTRL_DOUBLER] && wr_prediv != 6'h00) |=> pll2_ref_div_out == $past(wr_prediv))
    else $error("pre-divider not applied with doubler off");
  a_feed_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_04
    wr_ctrl |=> divider_feed_select_out == $past(reg_wdata_in[`CSPL_CTRL_FEED]))
    else $error("divider feed select did not follow write");
  a_intdiv_legal: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_06
    intdiv_supported(intdiv_q[0]) && intdiv_supported(intdiv_q[1]) && intdiv_supported(intdiv_q[2])
    && intdiv_supported(intdiv_q[3]))
    else $error("integer channel holds unsupported ratio");
  a_frac_limit: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_07
    fracint_q <= `CSPL_FRACINT_MAX)
    else $error("fractional integer part above limit");
  a_bypass_ref: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_17
    (wr_ctrl && reg_wdata_in[`CSPL_CTRL_BYPASS]) |=> ##1 (pll2_ref_from_input_out && lost == 2'h0))
    else $error("bypass did not select input reference or quiet monitors");
  c_vco_ok: cover property (@(posedge clk_sys_in) disable iff (rst_in) vco_config_ok_out);
  c_irq_low: cover property (@(posedge clk_sys_in) disable iff (rst_in) $fell(irq_out_low));
  c_clear_race: cover property (@(posedge clk_sys_in) disable iff (rst_in) wr_status && |lost_set);

endmodule : cspl_top

`default_nettype wire

/* File: sim/cspl_ref_model.sv */
// Behavioural divided VCXO and two reference clock sources for the loss monitors.
`timescale 1ns/100ps
`default_nettype none

module cspl_ref_model
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] run_in,
  input wire logic [4:0] ratio0_in,
  input wire logic [4:0] ratio1_in,
  output logic vcxo_div_out,
  output logic [1:0] ref_clk_out
);
  // The divided VCXO toggles every cycle, so each reference period spans ratio VCXO periods.
  logic [5:0] cyc_q [2];
  logic [5:0] per [2];

  assign per[0] = {ratio0_in, 1'b0};
  assign per[1] = {ratio1_in, 1'b0};

  always_ff @(posedge clk_sys_in)
  begin
    vcxo_div_out <= rst_in ? 1'b0 : ~vcxo_div_out;
  end

  // A stopped source freezes its level, which is what a dead input looks like to the monitor.
  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rst_in)
        cyc_q[i] <= 6'h00;
      else if (run_in[i])
        cyc_q[i] <= (cyc_q[i] + 6'h01 >= per[i]) ? 6'h00 : cyc_q[i] + 6'h01;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      ref_clk_out[i] = cyc_q[i] < {1'b0, per[i][5:1]};
  end
endmodule : cspl_ref_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the second-stage path controller and its loss monitors.
`timescale 1ns/100ps
`default_nettype none
`include "cspl_params.svh"

module tb;
  logic clk_sys_in, rst_in, wr, rd, vcxo, from_in, feed, man, ok, irq_low;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, idiv;
  logic [1:0] dz, run, live, lat, refc;
  logic [4:0] r0, r1;
  logic [5:0] pdiv;
  logic byp, dbl;
  logic [8:0] fbd;
  logic [3:0] fint;
  logic [23:0] ffrac;
  int bad_count = 0;
  int n_checks = 0;

  cspl_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .vcxo_div_in(vcxo), .ref_clk_in(refc),
    .diff_zero_in(dz), .first_stage_bypass_out(byp), .pll2_ref_from_input_out(from_in),
    .ref_doubler_on_out(dbl), .pll2_ref_div_out(pdiv), .second_stage_fb_div_out(fbd),
    .divider_feed_select_out(feed), .manual_select_required_out(man), .vco_config_ok_out(ok),
    .integer_channel_div_out(idiv), .fractional_channel_int_out(fint),
    .fractional_channel_frac_out(ffrac), .loss_live_flag_out(live), .loss_latched_flag_out(lat),
    .irq_out_low(irq_low));

  cspl_ref_model srcs (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .run_in(run), .ratio0_in(r0),
    .ratio1_in(r1), .vcxo_div_out(vcxo), .ref_clk_out(refc));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    #1;
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk_sys_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask : rchk

  // Polls are bounded; a flag that never moves is caught by the compare that follows.
  task automatic wait_live(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (live[i] !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_live

  function automatic logic [31:0] cw(input logic [8:0] f, input logic [5:0] p, input logic [2:0] m);
    return {7'h00, f, 2'h0, p, 5'h00, m};
  endfunction : cw

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rchk(`CSPL_ADDR_CTRL, 32'h000A_0102, "ctrl");
    cyc(1);
    chk("rdata_idle", rdata, 32'h0000_0000);
    rchk(`CSPL_ADDR_INTDIV, 32'h1414_1414, "intdiv");
    rchk(`CSPL_ADDR_LOSCFG, 32'h0008_0505, "loscfg");
    rchk(8'h40, 32'h0000_0000, "unmapped");
    chk("ok", {ok, irq_low}, 2'h3);
  endtask : t_reset

  task automatic t_path;
    wreg(`CSPL_ADDR_CTRL, cw(9'h014, 6'h01, 3'h0));
    chk("pdiv", {pdiv, ok}, 7'h03);
    chk("cfg", {byp, dbl, fbd}, 11'h014);
    wreg(`CSPL_ADDR_CTRL, cw(9'h014, 6'h02, 3'h0));
    chk("pdiv", {pdiv, ok}, 7'h04);
    wreg(`CSPL_ADDR_CTRL, cw(9'h00A, 6'h02, 3'h2));
    chk("pdiv", {pdiv, ok}, 7'h03);
    wreg(`CSPL_ADDR_CTRL, cw(9'h007, 6'h00, 3'h6));
    rchk(`CSPL_ADDR_CTRL, cw(9'h00A, 6'h02, 3'h6), "ctrl");
    chk("feed", feed, 1'b1);
    wreg(`CSPL_ADDR_CTRL, cw(9'h00A, 6'h02, 3'h3));
    chk("bypass", {feed, from_in, man, ok}, 4'h6);
    chk("cfg", {byp, dbl, fbd}, 11'h60A);
    wreg(`CSPL_ADDR_CTRL, cw(9'h00A, 6'h01, 3'h2));
  endtask : t_path

  task automatic t_divs;
    logic [7:0] legal [20] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h10, 8'h14, 8'h1E,
      8'h20, 8'h28, 8'h32, 8'h3C, 8'h40, 8'h50, 8'h64, 8'h78, 8'h80, 8'hA0};
    foreach (legal[i])
    begin
      wreg(`CSPL_ADDR_INTDIV, {4{legal[i]}});
      chk("idiv", idiv, {4{legal[i]}});
    end
    wreg(`CSPL_ADDR_LOSCFG, 32'h0003_1E1F);
    rchk(`CSPL_ADDR_LOSCFG, 32'h0003_1E1F, "loscfg");
    wreg(`CSPL_ADDR_LOSCFG, 32'h0008_0505);
    wreg(`CSPL_ADDR_INTDIV, 32'h0309_01C8);
    rchk(`CSPL_ADDR_INTDIV, 32'h03A0_01A0, "intdiv");
    wreg(`CSPL_ADDR_FRACINT, 32'h0000_000E);
    wreg(`CSPL_ADDR_FRACINT, 32'h0000_000F);
    wreg(`CSPL_ADDR_FRACINT, 32'h0000_0013);
    wreg(`CSPL_ADDR_FRACFRAC, 32'h00FF_FFFF);
    chk("frac", {fint, ffrac}, 28'hEFF_FFFF);
  endtask : t_divs

  task automatic t_los;
    int n;
    wreg(`CSPL_ADDR_MASK, 32'h0000_0003);
    cyc(100);
    chk("live", live, 2'h0);
    @(posedge clk_sys_in);
    run <= 2'h2;
    wait_live(0, 1'b1, 200, n);
    chk("early", n >= 20, 1'b1);
    chk("lost", {lat, live, irq_low}, 5'h0A);
    rchk(`CSPL_ADDR_STATUS, 32'h0000_0111, "status");
    @(posedge clk_sys_in);
    run <= 2'h3;
    cyc(50);
    chk("reval", live, 2'h1);
    wait_live(0, 1'b0, 150, n);
    chk("sticky", {lat, live}, 4'h4);
    wreg(`CSPL_ADDR_STATUS, 32'h0000_0010);
    chk("clear", {lat, irq_low}, 3'h1);
    wreg(`CSPL_ADDR_MASK, 32'h0000_0001);
    @(posedge clk_sys_in);
    dz <= 2'h2;
    cyc(2);
    chk("dz", {lat, live, irq_low}, 5'h15);
    @(posedge clk_sys_in);
    dz <= 2'h0;
    wait_live(1, 1'b0, 150, n);
    wreg(`CSPL_ADDR_STATUS, 32'h0000_0020);
    chk("dz", {lat, live}, 4'h0);
  endtask : t_los

  task automatic t_freq;
    int n = 0;
    @(posedge clk_sys_in);
    r0 <= 5'h02;
    r1 <= 5'h0A;
    repeat (300)
    begin
      cyc(1);
      if (live !== 2'h0)
        n++;
    end
    chk("freq", n, 32'h0);
    @(posedge clk_sys_in);
    r0 <= 5'h05;
    r1 <= 5'h05;
    cyc(50);
  endtask : t_freq

  task automatic t_bypass;
    int n;
    @(posedge clk_sys_in);
    run <= 2'h2;
    wait_live(0, 1'b1, 200, n);
    wreg(`CSPL_ADDR_CTRL, cw(9'h00A, 6'h01, 3'h3));
    cyc(100);
    chk("bypass", {lat, live}, 4'h4);
    @(posedge clk_sys_in);
    run <= 2'h3;
    wreg(`CSPL_ADDR_CTRL, cw(9'h00A, 6'h01, 3'h2));
    cyc(100);
    wreg(`CSPL_ADDR_STATUS, 32'h0000_0010);
    chk("resume", {lat, live}, 4'h0);
  endtask : t_bypass

  // ==========================================================================
  // Clock, sequence and watchdog
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  initial
  begin
    rst_in = 1'b1;
    {wr, rd, addr, wdata, dz} = '0;
    run = 2'h3;
    r0 = 5'h05;
    r1 = 5'h05;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset;
    t_path;
    t_divs;
    t_los;
    t_freq;
    t_bypass;
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    test_done;
  end
endmodule : tb
`default_nettype wire
